// File: include/sfq_map.vh
`ifndef SFQ_MAP_VH
`define SFQ_MAP_VH

// command opcodes
`define SFQ_OP_WRITE_ENABLE 8'h06
`define SFQ_OP_MODE_RESET 8'hFF
`define SFQ_OP_QUAD_READ 8'hEB
`define SFQ_OP_PAGE_PROGRAM_CMD 8'h02
`define SFQ_OP_QUAD_PROG 8'h32
`define SFQ_OP_SECTOR_ERASE 8'h20
`define SFQ_OP_BLOCK_ERASE 8'hD8

// mode nibble that keeps continuous read mode
`define SFQ_MODE_CONT 4'hA
`define SFQ_NIBBLE_ALL_ONE 4'hF

// frame layout, in bits or clocks
`define SFQ_ADDR_BITS 6'd24
`define SFQ_MODE_BITS 6'd8
`define SFQ_DUMMY_LAST 6'd3
`define SFQ_CMD_LAST 6'd7

// array geometry
`define SFQ_ARR_MSB 20
`define SFQ_BLK_LSB 16
`define SFQ_SECT_LSB 12
`define SFQ_PAGE_LSB 8
`define SFQ_BLOCK_COUNT 6'd32
`define SFQ_PAGE_LAST 8'hFF

// reset values
`define SFQ_RST_TIMER 32'h0000_0000
`define SFQ_RST_ADDR 24'h00_0000

`endif

// File: tb/sfq_cmd_assertions.sv
`default_nettype none
module sfq_cmd_sva #(
   parameter [31:0] PROG_CYCLES = 32'd20,
   parameter [31:0] SECT_CYCLES = 32'd40,
   parameter [31:0] BLOCK_CYCLES = 32'd60
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link pins
   input wire logic csN,
   input wire logic [3:0] dataLineOe,
   // status
   input wire logic writeEnableLatch,
   input wire logic busyFlag,
   // array ports
   input wire logic [20:0] memRdAddr,
   input wire logic pgmValid,
   input wire logic pgmReady,
   input wire logic [20:0] pgmAddr,
   input wire logic [7:0] pgmData,
   input wire logic eraseReq,
   input wire logic eraseBlock,
   input wire logic [20:0] eraseAddr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] busyLen_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the current busy stretch
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) busyLen_q <= 32'h0;
      else if (busyFlag) busyLen_q <= busyLen_q + 32'h1;
      else busyLen_q <= 32'h0;
   end
   a_erase_busy: assert property (eraseReq |-> ##[0:2] busyFlag)
      else $error("busy missing after erase start");
   a_erase_align: assert property (eraseReq |-> (eraseBlock ?
      eraseAddr[15:0] == 16'h0 : eraseAddr[11:0] == 12'h0))
      else $error("erase address not on region base");
   a_erase_latch: assert property (eraseReq |-> writeEnableLatch)
      else $error("erase started without latch");
   a_busy_latch_clr: assert property ($fell(busyFlag) |->
      !writeEnableLatch)
      else $error("latch still set after busy");
   a_busy_min_len: assert property ($fell(busyFlag) |->
      busyLen_q >= PROG_CYCLES)
      else $error("busy stretch too short");
   a_oe_released: assert property (csN [*5] |->
      dataLineOe == 4'h0)
      else $error("data lines driven while deselected");
   a_oe_whole: assert property (dataLineOe == 4'h0 ||
      dataLineOe == 4'hF)
      else $error("partial output enable");
   a_no_read_busy: assert property (busyFlag |->
      dataLineOe == 4'h0)
      else $error("read data driven while busy");
   a_pgm_in_busy: assert property (pgmValid |-> busyFlag)
      else $error("program word outside busy");
   a_pgm_hold: assert property (pgmValid && !pgmReady |=>
      pgmValid && $stable(pgmAddr) && $stable(pgmData))
      else $error("program word changed while stalled");
   a_rd_step: assert property (!csN && dataLineOe == 4'hF &&
      $past(dataLineOe) == 4'hF && $changed(memRdAddr) |->
      memRdAddr == $past(memRdAddr) + 21'h1)
      else $error("read address did not step by one");
endmodule
bind sfq_cmd_ctrl sfq_cmd_sva #(.PROG_CYCLES(PROG_CYCLES),
   .SECT_CYCLES(SECT_CYCLES), .BLOCK_CYCLES(BLOCK_CYCLES)) i_sva (
   .clk, .rst_n, .csN, .dataLineOe, .writeEnableLatch, .busyFlag,
   .memRdAddr, .pgmValid, .pgmReady, .pgmAddr, .pgmData, .eraseReq,
   .eraseBlock, .eraseAddr);
`default_nettype wire

// File: tb/sfq_host_model.sv
`default_nettype none
module sfq_host_model (
   // frame alignment clock
   input wire logic clk,
   // link pins
   output logic csN,
   output logic sck,
   output logic [3:0] hostVal,
   output logic [3:0] hostEn,
   // resolved data lines
   input wire logic [3:0] lines
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      hostVal = 4'h0;
      hostEn = 4'h0;
   end
   // sck idles low between frames
   // every pin change lands just after a clock edge
   task automatic open_frame();
      @(posedge clk);
      #1 csN = 1'b0;
   endtask
   task automatic close_frame();
      hostEn = 4'h0;
      #50 csN = 1'b1;
      #300;
   endtask
   // data set while low, sampled just before the fall
   task automatic cyc(input logic [3:0] v, input logic [3:0] e,
         output logic [3:0] r);
      hostVal = v;
      hostEn = e;
      #100 sck = 1'b1;
      #95 r = lines;
      #5 sck = 1'b0;
   endtask
   task automatic ser_byte(input logic [7:0] b);
      logic [3:0] r;
      for (int i = 7; i >= 0; i--) cyc({3'h0, b[i]}, 4'h1, r);
   endtask
   task automatic quad_byte(input logic [7:0] b, input logic [3:0] e,
         output logic [7:0] rb);
      logic [3:0] h;
      logic [3:0] l;
      cyc(b[7:4], e, h);
      cyc(b[3:0], e, l);
      rb = {h, l};
   endtask
endmodule
`default_nettype wire

// File: tb/sfq_tb.sv
`include "sfq_map.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk;
   logic rst_n;
   logic quadEnableBit;
   logic [3:0] protectBits;
   logic [7:0] memRdData;
   logic pgmReady;
   logic tgl;
   logic [31:0] seed = 32'hBDDEB4DD;
   int failures = 0;
   int comparisons = 0;
   logic [31:0] pe;
   logic [31:0] ee;
   logic [28:0] pQ[$];
   logic [21:0] eQ[$];
   wire logic csN, sck, writeEnableLatch, busyFlag, continuousMode;
   wire logic pgmValid, eraseReq, eraseBlock;
   wire logic [3:0] hostVal, hostEn, dataLineOut, dataLineOe, lines;
   wire logic [20:0] memRdAddr, pgmAddr, eraseAddr;
   wire logic [7:0] pgmData;
   // released lines toggle so a stale level is never mistaken for data
   assign lines = (dataLineOe & dataLineOut) |
      (~dataLineOe & hostEn & hostVal) | (~dataLineOe & ~hostEn & {4{tgl}});
   sfq_cmd_ctrl #(.PROG_CYCLES(32'd20), .SECT_CYCLES(32'd40),
      .BLOCK_CYCLES(32'd60)) i_dut (.clk, .rst_n, .csN, .sck,
      .dataLineIn(lines), .dataLineOut, .dataLineOe, .quadEnableBit,
      .protectBits, .writeEnableLatch, .busyFlag, .continuousMode,
      .memRdAddr, .memRdData, .pgmValid, .pgmReady, .pgmAddr, .pgmData,
      .eraseReq, .eraseBlock, .eraseAddr);
   sfq_host_model i_host (.clk, .csN, .sck, .hostVal, .hostEn, .lines);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] mem(input logic [20:0] a);
      return {3'h0, a[20:16]} ^ a[7:0];
   endfunction
   task automatic check(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // array side: sync read, stalling program port
   always @(posedge clk) begin
      #1;
      tgl = ~tgl;
      pgmReady = rnd() > 32'h4000_0000;
      memRdData = mem(memRdAddr);
   end
   always @(posedge clk) begin
      if (pgmValid === 1'b1 && pgmReady === 1'b1) begin
         pe = pQ.size() ? {3'h0, pQ.pop_front()} : 32'hFFFF_FFFF;
         check("pgmWord", {pgmAddr, pgmData}, pe);
      end
      if (eraseReq === 1'b1) begin
         ee = eQ.size() ? {10'h0, eQ.pop_front()} : 32'hFFFF_FFFF;
         check("eraseWord", {eraseBlock, eraseAddr},
            ee);
      end
   end
   task automatic cmd(input logic [7:0] op);
      i_host.open_frame();
      i_host.ser_byte(op);
      i_host.close_frame();
   endtask
   task automatic qread(input logic c, input logic [23:0] a,
         input logic [7:0] md, input int n);
      logic [7:0] r;
      logic [3:0] x;
      i_host.open_frame();
      if (c) i_host.ser_byte(`SFQ_OP_QUAD_READ);
      for (int i = 16; i >= 0; i -= 8) i_host.quad_byte(a[i+:8], 4'hF, r);
      i_host.quad_byte(md, 4'hF, r);
      repeat (4) i_host.cyc(4'h0, 4'h0, x);
      for (int i = 0; i < n; i++) begin
         i_host.quad_byte(8'h0, 4'h0, r);
         check("readByte", r, mem(21'(a[20:0] + i)));
      end
      i_host.close_frame();
      check("contMode", continuousMode,
         md[7:4] == `SFQ_MODE_CONT);
   endtask
   // program (n bytes) or erase (n zero); ok says whether it must run
   task automatic wr(input logic [7:0] op, input logic [23:0] a,
         input int n, input logic ok);
      logic [7:0] d[256];
      logic hit[256];
      logic [7:0] b;
      logic [7:0] r;
      logic q;
      logic lb;
      q = op == `SFQ_OP_QUAD_PROG;
      lb = writeEnableLatch;
      hit = '{default: 1'b0};
      i_host.open_frame();
      i_host.ser_byte(op);
      for (int i = 16; i >= 0; i -= 8) begin
         if (q) i_host.quad_byte(a[i+:8], 4'hF, r);
         else i_host.ser_byte(a[i+:8]);
      end
      for (int i = 0; i < n; i++) begin
         b = 8'(rnd());
         if (q) i_host.quad_byte(b, 4'hF, r);
         else i_host.ser_byte(b);
         d[8'(a[7:0] + i)] = b;
         hit[8'(a[7:0] + i)] = 1'b1;
      end
      for (int i = 0; i < 256; i++)
         if (ok && hit[i]) pQ.push_back({a[20:8], i[7:0], d[i]});
      if (ok && n == 0) eQ.push_back(op == `SFQ_OP_BLOCK_ERASE ?
         {1'b1, a[20:16], 16'h0} : {1'b0, a[20:12], 12'h0});
      i_host.close_frame();
      check("busyFlag", busyFlag, ok);
      if (ok && n == 0) begin
         i_host.open_frame();
         i_host.ser_byte(`SFQ_OP_QUAD_READ);
         repeat (4) i_host.quad_byte(8'hA0, 4'hF, r);
         i_host.close_frame();
         check("contBusy", continuousMode, 1'b0);
      end
      for (int k = 0; k < 2000 && busyFlag !== 1'b0; k++) @(posedge clk);
      check("busyDone", busyFlag, 1'b0);
      check("latch", writeEnableLatch, ok ? 1'b0 : lb);
      check("pgmLeft", pQ.size(), 0);
   endtask
   task automatic write_enable_cmd();
      cmd(`SFQ_OP_WRITE_ENABLE);
      check("latchSet", writeEnableLatch, 1'b1);
   endtask
   initial begin
      logic [3:0] x;
      rst_n = 1'b0;
      tgl = 1'b0;
      quadEnableBit = 1'b0;
      protectBits = 4'h0;
      memRdData = 8'h0;
      pgmReady = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      cmd(`SFQ_OP_MODE_RESET);
      qread(1'b1, 24'hFFFFFE, 8'hA5, 3);
      qread(1'b0, 24'h012345, 8'hA0, 2);
      // mode reset as seen in continuous mode: all-ones nibbles
      i_host.open_frame();
      repeat (4) i_host.cyc(4'hF, 4'hF, x);
      i_host.close_frame();
      check("modeReset", continuousMode, 1'b0);
      qread(1'b1, 24'h000100, 8'h5A, 1);
      wr(`SFQ_OP_PAGE_PROGRAM_CMD, 24'h0000FE, 3, 1'b0);
      write_enable_cmd();
      wr(`SFQ_OP_PAGE_PROGRAM_CMD, 24'hE345FE, 3, 1'b1);
      write_enable_cmd();
      wr(`SFQ_OP_QUAD_PROG, 24'h101210, 4, 1'b0);
      quadEnableBit = 1'b1;
      wr(`SFQ_OP_QUAD_PROG, 24'h101210, 258, 1'b1);
      write_enable_cmd();
      protectBits = 4'h1;
      wr(`SFQ_OP_PAGE_PROGRAM_CMD, 24'h1F0100, 2, 1'b0);
      protectBits = 4'h0;
      wr(`SFQ_OP_SECTOR_ERASE, 24'h7ABCDE, 0, 1'b1);
      write_enable_cmd();
      wr(`SFQ_OP_BLOCK_ERASE, 24'hEF8001, 0, 1'b1);
      wr(`SFQ_OP_SECTOR_ERASE, 24'h000000, 0, 1'b0);
      end_sim();
   end
   initial begin
      #1_000_000;
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire

// File: verilog/sfq_cmd_ctrl.v
`include "sfq_map.vh"
`default_nettype none

// Behaviour
// - quad read: command, then address and mode four bits per rising edge
// - mode nibble A keeps continuous quad read; device checks that nibble
// - after mode and four dummy clocks, data out per falling edge, MSB line 3
// - read address increments per byte and wraps to zero at array top
// - chip select high ends the read and releases the data lines
// - continuous mode: next frames start with address, until mode reset
// - quad read while busy is ignored, running cycle untouched
// - mode reset clears stored mode bits, ending continuous mode
// - page program: command, three address bytes, 1 to 256 serial bytes
// - program into a protected page is ignored
// - program needs the write-enable latch set first
// - program cycle starts only on select rise after a complete command
// - program busy: commands ignored, busy flag 1 until done
// - over 256 bytes wrap inside the page; last 256 kept
// - unsupplied bytes of the page keep their contents
// - program only clears bits; erase alone sets them
// - quad page program uses four lines; needs quad enable and latch
// - sector erase clears 4 Kbyte, starts on select rise
// - block erase clears 64 Kbyte, starts on select rise
// - erase needs the latch; latch clears when erase completes
// - erase busy: commands ignored, busy flag set until done
// - only address bits 20 to 0 are decoded
// - write enable command sets the write-enable latch
module sfq_cmd_ctrl #(
   parameter [31:0] PROG_CYCLES = 32'd20000,
   parameter [31:0] SECT_CYCLES = 32'd200000,
   parameter [31:0] BLOCK_CYCLES = 32'd800000
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // serial link pins
   input wire csN,
   input wire sck,
   input wire [3:0] dataLineIn,
   output reg [3:0] dataLineOut,
   output reg [3:0] dataLineOe,
   // configuration and status
   input wire quadEnableBit,
   input wire [3:0] protectBits,
   output reg writeEnableLatch,
   output wire busyFlag,
   output reg continuousMode,
   // array read port, one clock latency
   output reg [`SFQ_ARR_MSB:0] memRdAddr,
   input wire [7:0] memRdData,
   // array program port
   output wire pgmValid,
   input wire pgmReady,
   output wire [`SFQ_ARR_MSB:0] pgmAddr,
   output wire [7:0] pgmData,
   // array erase port
   output reg eraseReq,
   output reg eraseBlock,
   output reg [`SFQ_ARR_MSB:0] eraseAddr
);

   localparam [3:0] S_IDLE = 4'd0;
   localparam [3:0] S_CMD = 4'd1;
   localparam [3:0] S_ADDR = 4'd2;
   localparam [3:0] S_MODE = 4'd3;
   localparam [3:0] S_DUMMY = 4'd4;
   localparam [3:0] S_READ = 4'd5;
   localparam [3:0] S_PDATA = 4'd6;
   localparam [3:0] S_ERADDR = 4'd7;
   localparam [3:0] S_IGNORE = 4'd8;

   localparam [1:0] B_IDLE = 2'd0;
   localparam [1:0] B_DRAIN = 2'd1;
   localparam [1:0] B_WAIT = 2'd2;

   // top blocks made read-only by the protect field
   function isProt;
      input [3:0] bp;
      input [4:0] blk;
      reg [5:0] n;
      begin
         if (bp == 4'h0) begin
            n = 6'd0;
         end else if (bp > 4'h5) begin
            n = `SFQ_BLOCK_COUNT;
         end else begin
            n = 6'd1 << (bp - 4'h1);
         end
         isProt = (n != 6'd0) && ({1'b0, blk} >= (`SFQ_BLOCK_COUNT - n));
      end
   endfunction

   // link synchronisers
   reg csS1_q, csS2_q, csPrev_q;
   reg sckS1_q, sckS2_q, sckPrev_q;
   reg [3:0] dinS1_q, dinS2_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csS1_q <= 1'b1;
         csS2_q <= 1'b1;
         csPrev_q <= 1'b1;
         sckS1_q <= 1'b0;
         sckS2_q <= 1'b0;
         sckPrev_q <= 1'b0;
         dinS1_q <= 4'h0;
         dinS2_q <= 4'h0;
      end else begin
         csS1_q <= csN;
         csS2_q <= csS1_q;
         csPrev_q <= csS2_q;
         sckS1_q <= sck;
         sckS2_q <= sckS1_q;
         sckPrev_q <= sckS2_q;
         dinS1_q <= dataLineIn;
         dinS2_q <= dinS1_q;
      end
   end

   wire csFall = csPrev_q & ~csS2_q;
   wire csRise = ~csPrev_q & csS2_q;
   wire sckRise = ~sckPrev_q & sckS2_q & ~csS2_q;
   wire sckFall = sckPrev_q & ~sckS2_q & ~csS2_q;

   reg [3:0] st_q;
   reg [1:0] bst_q;
   reg [5:0] bitCnt_q;
   reg [23:0] shReg_q;
   reg [7:0] cmd_q;
   reg [23:0] addr_q;
   reg quadIn_q;
   reg contTx_q;
   reg allOnes_q;
   reg nibHi_q;
   reg [3:0] lowNib_q;
   reg [2:0] dataBits_q;
   reg [7:0] byteOff_q;
   reg byteSeen_q;
   reg [255:0] pageValid_q;
   reg [7:0] idx_q;
   reg [31:0] timer_q;
   reg [7:0] pageMem [0:255];

   wire busy = (bst_q != B_IDLE);
   assign busyFlag = busy;

   // four lines per edge, MSB on line 3, or one bit on line 0
   wire [23:0] shNext = quadIn_q ? {shReg_q[19:0], dinS2_q} :
                        {shReg_q[22:0], dinS2_q[0]};
   wire [5:0] bitsNext = bitCnt_q + (quadIn_q ? 6'd4 : 6'd1);
   wire [2:0] dataNext = dataBits_q + (quadIn_q ? 3'd4 : 3'd1);
   wire nibNotOnes = quadIn_q && (dinS2_q != `SFQ_NIBBLE_ALL_ONE);

   wire isQuadProg = (cmd_q == `SFQ_OP_QUAD_PROG);
   wire isBlockErase = (cmd_q == `SFQ_OP_BLOCK_ERASE);
   wire [4:0] tgtBlk = addr_q[`SFQ_ARR_MSB:`SFQ_BLK_LSB];

   // complete frame: whole bytes only, at least one
   wire progOk = (st_q == S_PDATA) && (dataBits_q == 3'd0) &&
                 byteSeen_q && writeEnableLatch &&
                 !isProt(protectBits, tgtBlk) &&
                 (!isQuadProg || quadEnableBit);
   wire eraseOk = (st_q == S_ERADDR) && writeEnableLatch &&
                  !isProt(protectBits, tgtBlk);
   wire goProg = csRise && !busy && progOk;
   wire goErase = csRise && !busy && eraseOk;

   wire pageWe = sckRise && (st_q == S_PDATA) && (dataNext == 3'd0);
   wire bufInReady;
   wire drainAdv = (bst_q == B_DRAIN) &&
                   (!pageValid_q[idx_q] || bufInReady);
   wire bufInValid = (bst_q == B_DRAIN) && pageValid_q[idx_q];

   // pushed byte only pulls bits low in the cell
   sfq_pair_buf #(
      .WIDTH(29),
      .DEPTH(2),
      .PTR(1)
   ) pgmBuf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData({addr_q[`SFQ_ARR_MSB:`SFQ_PAGE_LSB], idx_q,
               pageMem[idx_q]}),
      .outValid(pgmValid),
      .outReady(pgmReady),
      .outData({pgmAddr, pgmData})
   );

   // page staging store, no reset needed
   always @(posedge clk) begin
      if (pageWe) begin
         pageMem[byteOff_q] <= shNext[7:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         bst_q <= B_IDLE;
         bitCnt_q <= 6'd0;
         shReg_q <= `SFQ_RST_ADDR;
         cmd_q <= 8'h00;
         addr_q <= `SFQ_RST_ADDR;
         quadIn_q <= 1'b0;
         contTx_q <= 1'b0;
         allOnes_q <= 1'b0;
         nibHi_q <= 1'b1;
         lowNib_q <= 4'h0;
         dataBits_q <= 3'd0;
         byteOff_q <= 8'h00;
         byteSeen_q <= 1'b0;
         pageValid_q <= {256{1'b0}};
         idx_q <= 8'h00;
         timer_q <= `SFQ_RST_TIMER;
         writeEnableLatch <= 1'b0;
         continuousMode <= 1'b0;
         memRdAddr <= {(`SFQ_ARR_MSB+1){1'b0}};
         dataLineOut <= 4'h0;
         dataLineOe <= 4'h0;
         eraseReq <= 1'b0;
         eraseBlock <= 1'b0;
         eraseAddr <= {(`SFQ_ARR_MSB+1){1'b0}};
      end else begin
         eraseReq <= 1'b0;

         // self-timed cycle engine
         case (bst_q)
            B_IDLE: begin
               if (goProg) begin
                  bst_q <= B_DRAIN;
                  idx_q <= 8'h00;
                  timer_q <= PROG_CYCLES;
               end else if (goErase) begin
                  bst_q <= B_WAIT;
                  eraseReq <= 1'b1;
                  eraseBlock <= isBlockErase;
                  // clear the low bits of the region
                  if (isBlockErase) begin
                     eraseAddr <= {tgtBlk, 16'h0000};
                     timer_q <= BLOCK_CYCLES;
                  end else begin
                     eraseAddr <= {addr_q[`SFQ_ARR_MSB:`SFQ_SECT_LSB],
                                   12'h000};
                     timer_q <= SECT_CYCLES;
                  end
               end
            end
            B_DRAIN: begin
               // array back-pressure stalls the walk over the page
               if (drainAdv) begin
                  idx_q <= idx_q + 8'h01;
                  if (idx_q == `SFQ_PAGE_LAST) begin
                     bst_q <= B_WAIT;
                  end
               end
            end
            B_WAIT: begin
               // buffered words must reach the array before busy drops
               if (timer_q > 32'd1) begin
                  timer_q <= timer_q - 32'd1;
               end else if (!pgmValid) begin
                  bst_q <= B_IDLE;
                  writeEnableLatch <= 1'b0;
               end
            end
            default: begin
               bst_q <= B_IDLE;
            end
         endcase

         // frame engine
         if (csRise) begin
            st_q <= S_IDLE;
            dataLineOe <= 4'h0;
            // all-ones opening in continuous mode acts as mode reset
            if (contTx_q && allOnes_q &&
                (st_q == S_ADDR || st_q == S_MODE)) begin
               continuousMode <= 1'b0;
            end
         end else if (csFall) begin
            bitCnt_q <= 6'd0;
            shReg_q <= `SFQ_RST_ADDR;
            allOnes_q <= 1'b1;
            if (busy) begin
               st_q <= S_IGNORE;
               contTx_q <= 1'b0;
            end else if (continuousMode) begin
               st_q <= S_ADDR;
               cmd_q <= `SFQ_OP_QUAD_READ;
               quadIn_q <= 1'b1;
               contTx_q <= 1'b1;
            end else begin
               st_q <= S_CMD;
               quadIn_q <= 1'b0;
               contTx_q <= 1'b0;
            end
         end else if (sckRise) begin
            case (st_q)
               S_CMD: begin
                  shReg_q <= shNext;
                  bitCnt_q <= bitsNext;
                  if (bitCnt_q == `SFQ_CMD_LAST) begin
                     bitCnt_q <= 6'd0;
                     cmd_q <= shNext[7:0];
                     st_q <= S_ADDR;
                     case (shNext[7:0])
                        `SFQ_OP_WRITE_ENABLE: begin
                           writeEnableLatch <= 1'b1;
                           st_q <= S_IGNORE;
                        end
                        `SFQ_OP_MODE_RESET: begin
                           continuousMode <= 1'b0;
                           st_q <= S_IGNORE;
                        end
                        `SFQ_OP_QUAD_READ: begin
                           quadIn_q <= 1'b1;
                        end
                        `SFQ_OP_QUAD_PROG: begin
                           quadIn_q <= 1'b1;
                           pageValid_q <= {256{1'b0}};
                        end
                        `SFQ_OP_PAGE_PROGRAM_CMD: begin
                           pageValid_q <= {256{1'b0}};
                        end
                        `SFQ_OP_SECTOR_ERASE,
                        `SFQ_OP_BLOCK_ERASE: begin
                           quadIn_q <= 1'b0;
                        end
                        default: begin
                           st_q <= S_IGNORE;
                        end
                     endcase
                  end
               end
               S_ADDR: begin
                  shReg_q <= shNext;
                  bitCnt_q <= bitsNext;
                  if (nibNotOnes) begin
                     allOnes_q <= 1'b0;
                  end
                  if (bitsNext == `SFQ_ADDR_BITS) begin
                     bitCnt_q <= 6'd0;
                     addr_q <= shNext;
                     memRdAddr <= shNext[`SFQ_ARR_MSB:0];
                     byteOff_q <= shNext[7:0];
                     dataBits_q <= 3'd0;
                     byteSeen_q <= 1'b0;
                     if (cmd_q == `SFQ_OP_QUAD_READ) begin
                        st_q <= S_MODE;
                     end else if (cmd_q == `SFQ_OP_SECTOR_ERASE ||
                                  isBlockErase) begin
                        st_q <= S_ERADDR;
                     end else begin
                        st_q <= S_PDATA;
                     end
                  end
               end
               S_MODE: begin
                  bitCnt_q <= bitsNext;
                  if (nibNotOnes) begin
                     allOnes_q <= 1'b0;
                  end
                  if (bitCnt_q == 6'd0) begin
                     continuousMode <=
                        (dinS2_q == `SFQ_MODE_CONT);
                  end
                  if (bitsNext == `SFQ_MODE_BITS) begin
                     bitCnt_q <= 6'd0;
                     st_q <= S_DUMMY;
                  end
               end
               S_DUMMY: begin
                  bitCnt_q <= bitCnt_q + 6'd1;
                  if (bitCnt_q == `SFQ_DUMMY_LAST) begin
                     st_q <= S_READ;
                     nibHi_q <= 1'b1;
                  end
               end
               S_PDATA: begin
                  shReg_q <= shNext;
                  dataBits_q <= dataNext;
                  if (dataNext == 3'd0) begin
                     // offset wraps inside the page, newest byte wins
                     byteOff_q <= byteOff_q + 8'h01;
                     byteSeen_q <= 1'b1;
                     pageValid_q[byteOff_q] <= 1'b1;
                  end
               end
               S_ERADDR: begin
                  st_q <= S_IGNORE;
               end
               default: begin
               end
            endcase
         end else if (sckFall && st_q == S_READ) begin
            dataLineOe <= 4'hF;
            if (nibHi_q) begin
               dataLineOut <= memRdData[7:4];
               lowNib_q <= memRdData[3:0];
               nibHi_q <= 1'b0;
            end else begin
               dataLineOut <= lowNib_q;
               nibHi_q <= 1'b1;
               // address width wraps the top back to zero
               memRdAddr <= memRdAddr + 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// File: verilog/sfq_pair_buf.v
`default_nettype none

module sfq_pair_buf #(
   parameter WIDTH = 29,
   parameter DEPTH = 2,
   parameter PTR = 1
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // filling side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // draining side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);

   localparam [31:0] DEPTH_W = DEPTH;
   localparam [31:0] DEPTH_M1 = DEPTH - 1;
   localparam [PTR:0] FULL = DEPTH_W[PTR:0];
   localparam [PTR-1:0] LAST = DEPTH_M1[PTR-1:0];

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PTR-1:0] wrPtr_q;
   reg [PTR-1:0] rdPtr_q;
   reg [PTR:0] cnt_q;

   wire push = inValid & inReady;
   wire pop = outValid & outReady;

   assign inReady = (cnt_q != FULL);
   assign outValid = (cnt_q != {(PTR+1){1'b0}});
   assign outData = mem[rdPtr_q];

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= {PTR{1'b0}};
         rdPtr_q <= {PTR{1'b0}};
         cnt_q <= {(PTR+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == LAST) ? {PTR{1'b0}} : wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == LAST) ? {PTR{1'b0}} : rdPtr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire
